// ---- pllcc_pkg.sv ----
// Constants for the clock generation and divider control block.
// Assumes a 32-bit AXI4-Lite register bus; every register is one aligned word.
package pllcc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PLLCC_OFS_PLL_CONTROL_REG  = 8'h00;
  localparam logic [7:0] PLLCC_OFS_DIV      = 8'h04;
  localparam logic [7:0] PLLCC_OFS_REG_CTL  = 8'h08;
  localparam logic [7:0] PLLCC_OFS_SDR_CTL  = 8'h0C;
  localparam logic [7:0] PLLCC_OFS_AMG_CTL  = 8'h10;
  localparam logic [7:0] PLLCC_OFS_STATUS   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PLLCC_MULT_LSB   = 0;   // Multiplier code, 6 bits, 0 means 64
  localparam int PLLCC_MULT_W     = 6;
  localparam int PLLCC_HALF_BIT   = 6;   // Halve the reference before the VCO
  localparam int PLLCC_BYPASS_BIT = 8;
  localparam int PLLCC_SLEEP_BIT  = 10;  // Write-one request, reads zero
  localparam int PLLCC_DEEP_BIT   = 11;  // Write-one request, reads zero
  localparam int PLLCC_SYS_LSB    = 0;   // System divide field
  localparam int PLLCC_CORE_LSB   = 4;   // Core divide field
  localparam int PLLCC_BUFEN_BIT  = 0;   // Buffered reference output enable
  localparam int PLLCC_OUTEN_BIT  = 0;   // System clock pin enable

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] PLLCC_RST_MULT   = 6'h0A;
  localparam logic       PLLCC_RST_HALF   = 1'b0;
  localparam logic       PLLCC_RST_BYPASS = 1'b0;
  localparam logic [3:0] PLLCC_RST_SYS    = 4'h5;
  localparam logic [1:0] PLLCC_RST_CORE   = 2'h0;
  localparam logic       PLLCC_RST_BUFEN  = 1'b1;
  localparam logic       PLLCC_RST_OUTEN  = 1'b1;

  // ----------------------------------------------------------------
  // Bus answers and modes
  // ----------------------------------------------------------------
  localparam logic [1:0] PLLCC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PLLCC_RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    PLLCC_FULL_ON    = 4'b0001,
    PLLCC_ACTIVE     = 4'b0010,
    PLLCC_SLEEP      = 4'b0100,
    PLLCC_DEEP_SLEEP = 4'b1000
  } pllcc_mode_e;

endpackage

// ---- pllcc_top.sv ----
// Clock generation control: multiplier, core and system dividers, power modes, pins.
// Assumes aclk stands for the VCO output; ref_clock_in is sampled on aclk.
//
// Contract
// - The multiplier is programmable from 0.5x to 64x of the reference clock.
// - The multiplier resets to 10x and changes only by a write to the PLL control register.
// - Core and system clocks both derive from the reference clock, through the PLL except in bypass, where they take it directly.
// - A divider write changes core and system rates, each at its own divider's next wrap, with no lock wait.
// - The 4-bit system field divides the VCO by its binary value, 1 to 15.
// - The 2-bit core field divides the VCO by 1, 2, 4 or 8.
// - Peripherals take their clock from the system divider, never the core divider.
// - The buffered pin copies the reference, is on after reset, and has a regulator bit.
// - The system clock pin follows the system clock, on after reset, off via memory regs.
// - With bypass set and outside the sleep modes, both clocks run at the reference rate; a new multiplier waits.
// - Sleep stops the core clock while the PLL and system clock keep running.
// - Deep sleep stops both clocks until reset or a real-time-clock wake.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module pllcc_top #(
  parameter int SYS_DIV_W  = 4,
  parameter int CORE_DIV_W = 2
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    ref_clock_in,
  input  wire logic                    wake_event,
  input  wire logic                    rtc_wake,
  output logic                         core_clock,
  output logic                         core_tick,
  output logic                         sys_clock,
  output logic                         sys_tick,
  output logic                         system_clock_out,
  output logic                         buffered_ref_out,
  output pllcc_pkg::pllcc_mode_e       power_mode
);
  import pllcc_pkg::*;

  localparam int CCNT_W = (1 << CORE_DIV_W) - 1;

  if (SYS_DIV_W != 4 || CORE_DIV_W != 2)
  begin : g_bad_params
    $error("pllcc_top: divider fields must be 4 and 2 bits wide");
  end

  // ----------------------------------------------------------------
  // Register bus and control registers
  // ----------------------------------------------------------------
  logic                      aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]                aw_addr_q, aw_addr_d;
  logic [31:0]               w_data_q, w_data_d;
  logic [3:0]                w_strb_q, w_strb_d;
  logic                      awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]                bresp_d, rresp_d;
  logic [31:0]               rdata_d;
  logic [PLLCC_MULT_W-1:0]   mult_q, mult_d;
  logic                      half_q, half_d, bypass_q, bypass_d;
  logic                      sleep_req_q, sleep_req_d, deep_req_q, deep_req_d;
  logic [SYS_DIV_W-1:0]      sys_sel_q, sys_sel_d;
  logic [CORE_DIV_W-1:0]     core_sel_q, core_sel_d;
  logic                      bufen_q, bufen_d, sdr_en_q, sdr_en_d, amg_en_q, amg_en_d;
  logic [31:0]               wmask, old_word, new_word;
  logic                      do_write;
  logic [SYS_DIV_W-1:0]      sys_div_q, sys_div_d, sys_cnt_q, sys_cnt_d, sys_half;
  logic [CORE_DIV_W-1:0]     core_sel_act_q, core_sel_act_d;

  always_comb
  begin
    aw_got_d    = aw_got_q;
    w_got_d     = w_got_q;
    aw_addr_d   = aw_addr_q;
    w_data_d    = w_data_q;
    w_strb_d    = w_strb_q;
    awready_d   = s_axi_awready;
    wready_d    = s_axi_wready;
    bvalid_d    = s_axi_bvalid;
    bresp_d     = s_axi_bresp;
    arready_d   = s_axi_arready;
    rvalid_d    = s_axi_rvalid;
    rresp_d     = s_axi_rresp;
    rdata_d     = s_axi_rdata;
    mult_d      = mult_q;
    half_d      = half_q;
    bypass_d    = bypass_q;
    sys_sel_d   = sys_sel_q;
    core_sel_d  = core_sel_q;
    bufen_d     = bufen_q;
    sdr_en_d    = sdr_en_q;
    amg_en_d    = amg_en_q;
    sleep_req_d = 1'b0;
    deep_req_d  = 1'b0;
    wmask       = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    old_word    = 32'h0000_0000;
    do_write    = aw_got_q && w_got_q && !s_axi_bvalid;
    // Address and data are taken in either order, held until both are present
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_d  = 1'b1;
      aw_addr_d = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_d  = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
      wready_d = 1'b0;
    end
    unique case (aw_addr_q)
      PLLCC_OFS_PLL_CONTROL_REG: old_word = {23'h00_0000, bypass_q, 1'b0, half_q, mult_q};
      PLLCC_OFS_DIV:     old_word = {26'h000_0000, core_sel_q, sys_sel_q};
      PLLCC_OFS_REG_CTL: old_word = {31'h0000_0000, bufen_q};
      PLLCC_OFS_SDR_CTL: old_word = {31'h0000_0000, sdr_en_q};
      PLLCC_OFS_AMG_CTL: old_word = {31'h0000_0000, amg_en_q};
      default:           old_word = 32'h0000_0000;
    endcase
    new_word = (old_word & ~wmask) | (w_data_q & wmask);
    if (do_write)
    begin
      bvalid_d  = 1'b1;
      bresp_d   = PLLCC_RESP_OKAY;
      aw_got_d  = 1'b0;
      w_got_d   = 1'b0;
      unique case (aw_addr_q)
        PLLCC_OFS_PLL_CONTROL_REG:
        begin
          mult_d      = new_word[PLLCC_MULT_LSB +: PLLCC_MULT_W];
          half_d      = new_word[PLLCC_HALF_BIT];
          bypass_d    = new_word[PLLCC_BYPASS_BIT];
          sleep_req_d = new_word[PLLCC_SLEEP_BIT] & wmask[PLLCC_SLEEP_BIT];
          deep_req_d  = new_word[PLLCC_DEEP_BIT] & wmask[PLLCC_DEEP_BIT];
        end
        PLLCC_OFS_DIV:
        begin
          // A zero system code keeps the ratio in force
          if (new_word[PLLCC_SYS_LSB +: SYS_DIV_W] != '0)
          begin
            sys_sel_d = new_word[PLLCC_SYS_LSB +: SYS_DIV_W];
          end
          core_sel_d = new_word[PLLCC_CORE_LSB +: CORE_DIV_W];
        end
        PLLCC_OFS_REG_CTL: bufen_d  = new_word[PLLCC_BUFEN_BIT];
        PLLCC_OFS_SDR_CTL: sdr_en_d = new_word[PLLCC_OUTEN_BIT];
        PLLCC_OFS_AMG_CTL: amg_en_d = new_word[PLLCC_OUTEN_BIT];
        PLLCC_OFS_STATUS:  bresp_d  = PLLCC_RESP_OKAY;
        default:           bresp_d  = PLLCC_RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = PLLCC_RESP_OKAY;
      unique case (s_axi_araddr)
        PLLCC_OFS_PLL_CONTROL_REG: rdata_d = {23'h00_0000, bypass_q, 1'b0, half_q, mult_q};
        PLLCC_OFS_DIV:     rdata_d = {26'h000_0000, core_sel_q, sys_sel_q};
        PLLCC_OFS_REG_CTL: rdata_d = {31'h0000_0000, bufen_q};
        PLLCC_OFS_SDR_CTL: rdata_d = {31'h0000_0000, sdr_en_q};
        PLLCC_OFS_AMG_CTL: rdata_d = {31'h0000_0000, amg_en_q};
        PLLCC_OFS_STATUS:  rdata_d = {21'h00_0000, sys_div_q, 1'b0, core_sel_act_q, power_mode};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = PLLCC_RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power modes and dividers
  // ----------------------------------------------------------------
  pllcc_mode_e               mode_d;
  logic [PLLCC_MULT_W-1:0]   mult_act_q, mult_act_d;
  logic                      half_act_q, half_act_d;
  logic [CCNT_W-1:0]         core_cnt_q, core_cnt_d, core_last;
  logic                      ref_q, ref_prev_q, ref_rise;
  logic                      core_clock_d, core_tick_d, sys_clock_d, sys_tick_d;
  logic                      vco_core_lvl, vco_sys_lvl;

  always_comb
  begin
    mode_d         = power_mode;
    mult_act_d     = mult_act_q;
    half_act_d     = half_act_q;
    sys_div_d      = sys_div_q;
    sys_cnt_d      = sys_cnt_q + 1'b1;
    core_sel_act_d = core_sel_act_q;
    core_cnt_d     = core_cnt_q + 1'b1;
    core_last      = CCNT_W'((1 << core_sel_act_q) - 1);
    ref_rise       = ref_q && !ref_prev_q;
    unique case (power_mode)
      PLLCC_FULL_ON:
        if (deep_req_q)          mode_d = PLLCC_DEEP_SLEEP;
        else if (sleep_req_q)    mode_d = PLLCC_SLEEP;
        else if (bypass_q)       mode_d = PLLCC_ACTIVE;
      PLLCC_ACTIVE:
        if (deep_req_q)          mode_d = PLLCC_DEEP_SLEEP;
        else if (sleep_req_q)    mode_d = PLLCC_SLEEP;
        else if (!bypass_q)      mode_d = PLLCC_FULL_ON;
      PLLCC_SLEEP:
        if (wake_event)          mode_d = bypass_q ? PLLCC_ACTIVE : PLLCC_FULL_ON;
      PLLCC_DEEP_SLEEP:
        if (rtc_wake)            mode_d = PLLCC_ACTIVE;
    endcase
    // The multiplier reaches the VCO only outside bypass
    if (!bypass_q)
    begin
      mult_act_d = mult_q;
      half_act_d = half_q;
    end
    // New ratios load only at the wrap, so no shortened phase appears
    if (sys_cnt_q == sys_div_q - 1'b1)
    begin
      sys_cnt_d = '0;
      sys_div_d = sys_sel_q;
    end
    if (core_cnt_q == core_last)
    begin
      core_cnt_d     = '0;
      core_sel_act_d = core_sel_q;
    end
    sys_half     = SYS_DIV_W'(({1'b0, sys_div_q} + 1'b1) >> 1);
    vco_sys_lvl  = sys_cnt_d < sys_half;
    vco_core_lvl = core_cnt_d <= (core_last >> 1);
    // The active mode runs both clocks from the reference; every other mode from the VCO
    if (mode_d == PLLCC_ACTIVE)
    begin
      core_clock_d = ref_q;
      core_tick_d  = ref_rise;
      sys_clock_d  = ref_q;
      sys_tick_d   = ref_rise;
    end
    else
    begin
      core_clock_d = vco_core_lvl;
      core_tick_d  = core_cnt_d == '0;
      sys_clock_d  = vco_sys_lvl;
      sys_tick_d   = sys_cnt_d == '0;
    end
    if (mode_d == PLLCC_SLEEP || mode_d == PLLCC_DEEP_SLEEP)
    begin
      core_clock_d = 1'b0;
      core_tick_d  = 1'b0;
    end
    if (mode_d == PLLCC_DEEP_SLEEP)
    begin
      sys_clock_d = 1'b0;
      sys_tick_d  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q         <= 1'b0;
      w_got_q          <= 1'b0;
      aw_addr_q        <= 8'h00;
      w_data_q         <= 32'h0000_0000;
      w_strb_q         <= 4'h0;
      s_axi_awready    <= 1'b1;
      s_axi_wready     <= 1'b1;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= PLLCC_RESP_OKAY;
      s_axi_arready    <= 1'b1;
      s_axi_rvalid     <= 1'b0;
      s_axi_rresp      <= PLLCC_RESP_OKAY;
      s_axi_rdata      <= 32'h0000_0000;
      mult_q           <= PLLCC_RST_MULT;
      half_q           <= PLLCC_RST_HALF;
      bypass_q         <= PLLCC_RST_BYPASS;
      sleep_req_q      <= 1'b0;
      deep_req_q       <= 1'b0;
      sys_sel_q        <= PLLCC_RST_SYS;
      core_sel_q       <= PLLCC_RST_CORE;
      bufen_q          <= PLLCC_RST_BUFEN;
      sdr_en_q         <= PLLCC_RST_OUTEN;
      amg_en_q         <= PLLCC_RST_OUTEN;
      power_mode       <= PLLCC_FULL_ON;
      mult_act_q       <= PLLCC_RST_MULT;
      half_act_q       <= PLLCC_RST_HALF;
      sys_div_q        <= PLLCC_RST_SYS;
      sys_cnt_q        <= '0;
      core_sel_act_q   <= PLLCC_RST_CORE;
      core_cnt_q       <= '0;
      ref_q            <= 1'b0;
      ref_prev_q       <= 1'b0;
      core_clock       <= 1'b0;
      core_tick        <= 1'b0;
      sys_clock        <= 1'b0;
      sys_tick         <= 1'b0;
      system_clock_out <= 1'b0;
      buffered_ref_out <= 1'b0;
    end
    else
    begin
      aw_got_q         <= aw_got_d;
      w_got_q          <= w_got_d;
      aw_addr_q        <= aw_addr_d;
      w_data_q         <= w_data_d;
      w_strb_q         <= w_strb_d;
      s_axi_awready    <= awready_d;
      s_axi_wready     <= wready_d;
      s_axi_bvalid     <= bvalid_d;
      s_axi_bresp      <= bresp_d;
      s_axi_arready    <= arready_d;
      s_axi_rvalid     <= rvalid_d;
      s_axi_rresp      <= rresp_d;
      s_axi_rdata      <= rdata_d;
      mult_q           <= mult_d;
      half_q           <= half_d;
      bypass_q         <= bypass_d;
      sleep_req_q      <= sleep_req_d;
      deep_req_q       <= deep_req_d;
      sys_sel_q        <= sys_sel_d;
      core_sel_q       <= core_sel_d;
      bufen_q          <= bufen_d;
      sdr_en_q         <= sdr_en_d;
      amg_en_q         <= amg_en_d;
      power_mode       <= mode_d;
      mult_act_q       <= mult_act_d;
      half_act_q       <= half_act_d;
      sys_div_q        <= sys_div_d;
      sys_cnt_q        <= sys_cnt_d;
      core_sel_act_q   <= core_sel_act_d;
      core_cnt_q       <= core_cnt_d;
      ref_q            <= ref_clock_in;
      ref_prev_q       <= ref_q;
      core_clock       <= core_clock_d;
      core_tick        <= core_tick_d;
      sys_clock        <= sys_clock_d;
      sys_tick         <= sys_tick_d;
      system_clock_out <= sys_clock_d & (sdr_en_q | amg_en_q);
      buffered_ref_out <= ref_clock_in & bufen_q;
    end
  end

endmodule // pllcc_top

// ---- pllcc_assertions.sv ----
// Concurrent checks for the clock generation and divider control block.
// Assumes it is bound to pllcc_top and sees only that module's ports.
`timescale 1ns/1ps
module pllcc_assertions
  import pllcc_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             ref_clock_in,
  input wire logic             core_clock,
  input wire logic             core_tick,
  input wire logic             sys_clock,
  input wire logic             sys_tick,
  input wire logic             system_clock_out,
  input wire logic             buffered_ref_out,
  input pllcc_pkg::pllcc_mode_e power_mode
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------
  // Mode and write sequences
  // ------
  // Two or three cycles of a mode give the registered clock outputs time to follow it
  sequence s_sleep;
    (power_mode == PLLCC_SLEEP) [*2];
  endsequence
  sequence s_deep;
    (power_mode == PLLCC_DEEP_SLEEP) [*2];
  endsequence
  sequence s_active;
    (power_mode == PLLCC_ACTIVE) [*3];
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // ------
  // Properties
  // ------
  a_reset_state: assert property (
    $rose(aresetn) |-> power_mode == PLLCC_FULL_ON && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state after reset wrong");
  a_write_answer: assert property (
    s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_write_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");
  a_buf_copy: assert property (
    buffered_ref_out |-> $past(ref_clock_in))
    else $error("buffered pin high without reference");
  a_pin_follows: assert property (
    system_clock_out |-> sys_clock)
    else $error("system pin high without system clock");
  a_sleep_gates: assert property (
    s_sleep |-> !core_clock && !core_tick)
    else $error("core clock runs in sleep");
  a_deep_gates: assert property (
    s_deep |-> !core_clock && !core_tick && !sys_clock && !sys_tick)
    else $error("clocks run in deep sleep");
  a_active_ref: assert property (
    s_active |-> core_clock == $past(ref_clock_in, 2) && sys_clock == core_clock)
    else $error("bypassed clocks do not follow reference");
  a_sys_in_sleep: assert property (
    s_sleep |-> ##[0:40] sys_tick)
    else $error("system clock stopped in sleep");
endmodule // pllcc_assertions

// ---- pllcc_ref_osc.sv ----
// Reference oscillator standing at the clock input of the block.
// Assumes the block samples it on aclk; its edges sit 5 ns off the aclk edges.
`timescale 1ns/1ps
module pllcc_ref_osc #(
  parameter int HALF_NS = 80
) (
  output logic ref_clock_in
);
  // Never halted and never changes rate, so the bypassed clocks and the buffered pin always see a steady input
  initial
  begin
    ref_clock_in = 1'b0;
    #5;
    forever #HALF_NS ref_clock_in = ~ref_clock_in;
  end
endmodule // pllcc_ref_osc

// ---- tb_pllcc_top.sv ----
// Self-checking bench for the clock generation and divider control block.
// Assumes pllcc_top, pllcc_assertions and pllcc_ref_osc are compiled before it.
`timescale 1ns/1ps
module tb_pllcc_top;
  import pllcc_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, ref_clock_in, wake_event, rtc_wake, core_clock, core_tick;
  logic        sys_clock, sys_tick, system_clock_out, buffered_ref_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  pllcc_mode_e power_mode;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          n_errors = 0;
  int          n_compared = 0;
  int          tbl[4] = '{1, 6, 10, 15};

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  pllcc_ref_osc u_osc (.ref_clock_in);
  pllcc_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ref_clock_in, .wake_event, .rtc_wake, .core_clock,
    .core_tick, .sys_clock, .sys_tick, .system_clock_out, .buffered_ref_out, .power_mode
  );

  // ------
  // Checking and closing
  // ------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Results are taken at the edge where the answer is accepted
  always @(posedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
    begin
      chk("rdata", 32'(rq[0][31:0]), s_axi_rdata);
      chk("rresp", 32'(rq[0][33:32]), 32'(s_axi_rresp));
      void'(rq.pop_front());
    end
  end

  // ------
  // Bus and probe tasks
  // ------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid === 1'b1 && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50)
    begin
      n_errors++;
      test_done();
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid === 1'b1 && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50)
    begin
      n_errors++;
      test_done();
    end
    @(posedge aclk);
  endtask

  task automatic wtick(input bit c, output int k);
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end
    while (((c ? core_tick : sys_tick) !== 1'b1) && k < 100);
    if (k >= 100)
    begin
      n_errors++;
      test_done();
    end
  endtask

  // Two ticks are skipped first, since a new ratio only lands on a period boundary
  task automatic per(input bit c, input int e);
    int k;
    wtick(c, k);
    wtick(c, k);
    wtick(c, k);
    chk(c ? "core_period" : "sys_period", e, k);
  endtask

  task automatic watch(input int s, output int hi);
    hi = 0;
    repeat (40)
    begin
      @(posedge aclk);
      case (s)
        0: hi += (buffered_ref_out === 1'b1);
        1: hi += (system_clock_out === 1'b1);
        2: hi += (core_clock === 1'b1);
        default: hi += (sys_clock === 1'b1);
      endcase
    end
  endtask

  task automatic wmode(input pllcc_mode_e m);
    int k;
    k = 0;
    while (power_mode !== m && k < 20)
    begin
      @(posedge aclk);
      k++;
    end
    chk("power_mode", 32'(m), 32'(power_mode));
    if (power_mode !== m) test_done();
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    int s, c, hi;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, wake_event, rtc_wake, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(29));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_000A, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_DIV, 32'h0000_0005, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_REG_CTL, 32'h0000_0001, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_SDR_CTL, 32'h0000_0001, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_AMG_CTL, 32'h0000_0001, PLLCC_RESP_OKAY);
    rd(8'h18, 32'h0000_0000, PLLCC_RESP_SLVERR);
    wr(8'h1C, 32'h0000_0003, PLLCC_RESP_SLVERR);
    wr(PLLCC_OFS_STATUS, 32'h0000_0000, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_STATUS, 32'h0000_0281, PLLCC_RESP_OKAY);
    per(0, 5);
    for (int i = 0; i < 7; i++)
    begin
      s = (i < 4) ? tbl[i] : $urandom_range(15, 1);
      c = (i < 4) ? i : $urandom_range(3, 0);
      wr(PLLCC_OFS_DIV, 32'((c << 4) | s), PLLCC_RESP_OKAY);
      rd(PLLCC_OFS_DIV, 32'((c << 4) | s), PLLCC_RESP_OKAY);
      per(0, s);
      per(1, 1 << c);
    end
    wr(PLLCC_OFS_DIV, 32'h0000_0030, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_DIV, 32'(48 | s), PLLCC_RESP_OKAY);
    per(0, s);
    wr(PLLCC_OFS_DIV, 32'h0000_0005, PLLCC_RESP_OKAY);
    wr(PLLCC_OFS_SDR_CTL, 32'h0000_0000, PLLCC_RESP_OKAY);
    watch(1, hi);
    chk("pin_either", 1, hi > 0);
    wr(PLLCC_OFS_AMG_CTL, 32'h0000_0000, PLLCC_RESP_OKAY);
    watch(1, hi);
    chk("pin_off", 0, hi);
    wr(PLLCC_OFS_SDR_CTL, 32'h0000_0001, PLLCC_RESP_OKAY);
    watch(1, hi);
    chk("pin_on", 1, hi > 0);
    wr(PLLCC_OFS_REG_CTL, 32'h0000_0000, PLLCC_RESP_OKAY);
    watch(0, hi);
    chk("buf_off", 0, hi);
    wr(PLLCC_OFS_REG_CTL, 32'h0000_0001, PLLCC_RESP_OKAY);
    watch(0, hi);
    chk("buf_on", 1, hi > 0);
    wr(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_017F, PLLCC_RESP_OKAY);
    rd(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_017F, PLLCC_RESP_OKAY);
    wmode(PLLCC_ACTIVE);
    watch(2, hi);
    chk("core_on_ref", 1, hi > 0);
    wr(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_040A, PLLCC_RESP_OKAY);
    wmode(PLLCC_SLEEP);
    watch(2, hi);
    chk("core_sleep", 0, hi);
    watch(3, hi);
    chk("sys_sleep", 1, hi > 0);
    rd(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_000A, PLLCC_RESP_OKAY);
    wake_event <= 1'b1;
    wmode(PLLCC_FULL_ON);
    wake_event <= 1'b0;
    wr(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_080A, PLLCC_RESP_OKAY);
    wmode(PLLCC_DEEP_SLEEP);
    watch(3, hi);
    chk("sys_deep", 0, hi);
    rtc_wake <= 1'b1;
    wmode(PLLCC_ACTIVE);
    rtc_wake <= 1'b0;
    wr(PLLCC_OFS_PLL_CONTROL_REG, 32'h0000_080A, PLLCC_RESP_OKAY);
    wmode(PLLCC_DEEP_SLEEP);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("mode_reset", 32'(PLLCC_FULL_ON), 32'(power_mode));
    rd(PLLCC_OFS_DIV, 32'h0000_0005, PLLCC_RESP_OKAY);
    test_done();
  end

  // A hang counts as a mismatch and still reaches the verdict
  initial
  begin
    repeat (100000) @(posedge aclk);
    n_errors++;
    test_done();
  end
endmodule // tb_pllcc_top

bind pllcc_top pllcc_assertions u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ref_clock_in, .core_clock,
  .core_tick, .sys_clock, .sys_tick, .system_clock_out, .buffered_ref_out, .power_mode
);
